/* File: pkg/bmfs_pkg.sv */
// constants and types shared by the ballast mode fault sequencer
// How it works
// - preheat moves to strike when the preheat timer comparator reports above 10V
// - over-current tally leads to fault only in preheat and strike
// - an over-current event counts only during bottom gate on-time
// - in strike, more than 25 counted events enter fault, gates latched low
// - in run, one over-current event enters fault at once
// - in run, lamp sense above 3V or below 1V enters fault
// - fault holds all gates low and discharges both timing nodes
// - fault exits to lockout on supply drop or shutdown above 5.2V
// - lockout goes to preheat when supply is good and shutdown below 5.0V
// - bus sense below 3.0V discharges supply and latches gates low
// - strike ramps half-bridge frequency smoothly from preheat to run value
// - boost gate turns on again only after zero inductor current seen
// - lockout holds both half-bridge gates low and grounds timing nodes
// - oscillation starts with a bottom gate pulse
// - gates alternate with dead time between pulses, at equal on-times except while the strike ramp runs
package bmfs_pkg;
    typedef enum logic [2:0] {
        BMFS_LOCKOUT = 3'h0,
        BMFS_WARM    = 3'h1,
        BMFS_STRIKE  = 3'h2,
        BMFS_RUN     = 3'h3,
        BMFS_FAULT   = 3'h4
    } bmfs_state_e;

    localparam int BMFS_FAULT_LIMIT = 25;
    localparam int BMFS_CNT_W = 7;
    localparam int BMFS_PER_W = 12;
    // half periods, dead time, ramp step and boost on-time in clock cycles (40 MHz)
    localparam logic [11:0] BMFS_WARM_HALF = 12'h050;
    localparam logic [11:0] BMFS_RUN_HALF = 12'h0C8;
    localparam logic [11:0] BMFS_DEAD_CYC = 12'h010;
    localparam logic [11:0] BMFS_RAMP_STEP = 12'h001;
    localparam logic [11:0] BMFS_BOOST_ON = 12'h064;
    localparam int BMFS_NFLAGS = 11;
endpackage

/* File: pkg/bmfs_sync_if.sv */
// carries raw and synchronised comparator flags
`timescale 1ns/1ps
interface bmfs_sync_if #(parameter int N = 11);
    logic [N-1:0] raw;
    logic [N-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user (output raw, input sync);
endinterface

/* File: hdl/bmfs_sync.sv */
// two-stage synchroniser for comparator flags
`timescale 1ns/1ps
module bmfs_sync #(
    parameter int N = 11
) (
    input wire logic clock,
    input wire logic sys_rst,
    bmfs_sync_if.sync_side flags
);
    logic [N-1:0] meta_ff;
    logic [N-1:0] sync_ff;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= flags.raw;
            sync_ff <= meta_ff;
        end
    end

    assign flags.sync = sync_ff;
endmodule

/* File: hdl/bmfs_osc.sv */
// half-bridge oscillator: alternating gates with dead time and ramp
`timescale 1ns/1ps
module bmfs_osc
    import bmfs_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic run_en,
    input wire logic ramp_en,
    output logic hi_on,
    output logic lo_on,
    output logic lo_window
);
    logic [BMFS_PER_W-1:0] half_ff;
    logic [BMFS_PER_W-1:0] cnt_ff;
    logic dead_ff;
    logic side_ff;

    // frequency creeps one step per clock from preheat to run half period;
    // a phase in progress stretches with it, so no runt pulse appears
    always_ff @(posedge clock) begin
        if (sys_rst || !run_en) begin
            half_ff <= BMFS_WARM_HALF;
        end else if (ramp_en && half_ff < BMFS_RUN_HALF) begin
            half_ff <= half_ff + BMFS_RAMP_STEP;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || !run_en) begin
            cnt_ff <= '0;
            dead_ff <= 1'b0;
            side_ff <= 1'b0;
        end else if (dead_ff) begin
            if (cnt_ff >= BMFS_DEAD_CYC - 12'h001) begin
                cnt_ff <= '0;
                dead_ff <= 1'b0;
            end else begin
                cnt_ff <= cnt_ff + 12'h001;
            end
        end else if (cnt_ff >= half_ff - 12'h001) begin
            cnt_ff <= '0;
            dead_ff <= 1'b1;
            side_ff <= ~side_ff;
        end else begin
            cnt_ff <= cnt_ff + 12'h001;
        end
    end

    assign lo_on = run_en && !dead_ff && !side_ff;
    assign hi_on = run_en && !dead_ff && side_ff;
    assign lo_window = lo_on;
endmodule

/* File: hdl/bmfs_top.sv */
// ballast mode fault sequencer top
`timescale 1ns/1ps
module bmfs_top
    import bmfs_pkg::*;
#(
    parameter int FAULT_LIMIT = BMFS_FAULT_LIMIT
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic supply_on_ok,
    input wire logic supply_off_low,
    input wire logic preheat_above_10v,
    input wire logic current_sense_over,
    input wire logic lamp_sense_above_3v,
    input wire logic lamp_sense_below_1v,
    input wire logic shutdown_above_5v2,
    input wire logic shutdown_below_5v0,
    input wire logic bus_sense_below_3v,
    input wire logic zero_current_seen,
    input wire logic spare_flag,
    output logic high_side_gate,
    output logic bottom_switch_gate,
    output logic boost_switch_gate,
    output logic preheat_timer_node_discharge,
    output logic oscillator_timing_node_discharge,
    output logic supply_discharge,
    output bmfs_pkg::bmfs_state_e state_out
);
    import bmfs_pkg::*;

    bmfs_sync_if #(.N(BMFS_NFLAGS)) flags ();

    assign flags.raw = {spare_flag, zero_current_seen, bus_sense_below_3v,
        shutdown_below_5v0, shutdown_above_5v2, lamp_sense_below_1v,
        lamp_sense_above_3v, current_sense_over, preheat_above_10v,
        supply_off_low, supply_on_ok};

    bmfs_sync #(.N(BMFS_NFLAGS)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .flags(flags)
    );

    logic s_on_ok;
    logic s_off_low;
    logic s_ph10;
    logic s_cs;
    logic s_ls_hi;
    logic s_ls_lo;
    logic s_sd_hi;
    logic s_sd_lo;
    logic s_bus_low;
    logic s_zx;

    // synchronised flags only, never the raw pins
    assign s_on_ok = flags.sync[0];
    assign s_off_low = flags.sync[1];
    assign s_ph10 = flags.sync[2];
    assign s_cs = flags.sync[3];
    assign s_ls_hi = flags.sync[4];
    assign s_ls_lo = flags.sync[5];
    assign s_sd_hi = flags.sync[6];
    assign s_sd_lo = flags.sync[7];
    assign s_bus_low = flags.sync[8];
    assign s_zx = flags.sync[9];

    // ********************************************************
    // state
    // ********************************************************
    bmfs_state_e state_ff;
    bmfs_state_e nxt_state;
    logic cs_prev_ff;
    logic [BMFS_CNT_W-1:0] ocnt_ff;
    logic bus_latch_ff;
    logic osc_en;
    logic hi_on;
    logic lo_on;
    logic lo_win;
    logic cs_edge;
    logic cs_counted;
    logic ramp_done;
    logic [BMFS_PER_W-1:0] ramp_cnt_ff;

    assign cs_edge = s_cs && !cs_prev_ff;
    assign cs_counted = cs_edge && lo_win;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            BMFS_LOCKOUT: begin
                if (s_on_ok && s_sd_lo && !bus_latch_ff) begin
                    nxt_state = BMFS_WARM;
                end
            end
            BMFS_WARM: begin
                if (cs_counted && ocnt_ff >= BMFS_CNT_W'(FAULT_LIMIT)) begin
                    nxt_state = BMFS_FAULT;
                end else if (s_ph10) begin
                    nxt_state = BMFS_STRIKE;
                end
            end
            BMFS_STRIKE: begin
                if (cs_counted && ocnt_ff >= BMFS_CNT_W'(FAULT_LIMIT)) begin
                    nxt_state = BMFS_FAULT;
                // no lamp-lit input: strike ends when the ramp timer expires
                end else if (ramp_done) begin
                    nxt_state = BMFS_RUN;
                end
            end
            BMFS_RUN: begin
                if (cs_edge || s_ls_hi || s_ls_lo) begin
                    nxt_state = BMFS_FAULT;
                end
            end
            BMFS_FAULT: begin
                if (s_off_low || s_sd_hi) begin
                    nxt_state = BMFS_LOCKOUT;
                end
            end
            default: nxt_state = BMFS_FAULT;
        endcase
        // supply low or shutdown forces lockout from any state; a set bus latch overrides it with fault
        if (state_ff != BMFS_LOCKOUT && (s_off_low || s_sd_hi)) begin
            nxt_state = BMFS_LOCKOUT;
        end
        if (bus_latch_ff && state_ff != BMFS_LOCKOUT) begin
            nxt_state = BMFS_FAULT;
        end
    end

    // strike lasts long enough for the frequency ramp to reach run value
    assign ramp_done = ramp_cnt_ff == (BMFS_RUN_HALF - BMFS_WARM_HALF)
        * 12'h002 + BMFS_RUN_HALF;

    always_ff @(posedge clock) begin
        if (sys_rst || state_ff != BMFS_STRIKE) begin
            ramp_cnt_ff <= '0;
        end else if (!ramp_done) begin
            ramp_cnt_ff <= ramp_cnt_ff + 12'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_ff <= BMFS_LOCKOUT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ********************************************************
    // over-current tally
    // ********************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cs_prev_ff <= 1'b0;
        end else begin
            cs_prev_ff <= s_cs;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || state_ff == BMFS_LOCKOUT) begin
            ocnt_ff <= '0;
        end else if ((state_ff == BMFS_WARM || state_ff == BMFS_STRIKE)
                && cs_counted && ocnt_ff != '1) begin
            ocnt_ff <= ocnt_ff + 7'h01;
        end
    end

    // ********************************************************
    // bus undervoltage latch: held until supply recycles
    // ********************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus_latch_ff <= 1'b0;
        end else if (s_bus_low && state_ff != BMFS_LOCKOUT) begin
            bus_latch_ff <= 1'b1;
        end else if (s_off_low) begin
            bus_latch_ff <= 1'b0;
        end
    end

    // ********************************************************
    // oscillator and boost gate
    // ********************************************************
    assign osc_en = (state_ff == BMFS_WARM || state_ff == BMFS_STRIKE
        || state_ff == BMFS_RUN) && !bus_latch_ff;

    bmfs_osc u_osc (
        .clock(clock),
        .sys_rst(sys_rst),
        .run_en(osc_en),
        .ramp_en(state_ff == BMFS_STRIKE),
        .hi_on(hi_on),
        .lo_on(lo_on),
        .lo_window(lo_win)
    );

    logic boost_on_ff;
    logic armed_ff;
    logic boost_last;
    logic [BMFS_PER_W-1:0] bcnt_ff;

    assign boost_last = bcnt_ff >= BMFS_BOOST_ON - 12'h001;

    // fixed on-time counter, idle at zero while the gate is off
    always_ff @(posedge clock) begin
        if (sys_rst || !osc_en || !boost_on_ff || boost_last) begin
            bcnt_ff <= '0;
        end else begin
            bcnt_ff <= bcnt_ff + 12'h001;
        end
    end

    // a new pulse starts only once armed
    always_ff @(posedge clock) begin
        if (sys_rst || !osc_en) begin
            boost_on_ff <= 1'b0;
        end else if (boost_on_ff) begin
            boost_on_ff <= !boost_last;
        end else if (armed_ff) begin
            boost_on_ff <= 1'b1;
        end
    end

    // the first pulse after enable needs no zero-current proof, since
    // the inductor starts empty; later ones wait for the zero flag
    always_ff @(posedge clock) begin
        if (sys_rst || !osc_en) begin
            armed_ff <= 1'b1;
        end else if (boost_on_ff && boost_last) begin
            armed_ff <= 1'b0;
        end else if (!boost_on_ff && s_zx) begin
            armed_ff <= 1'b1;
        end
    end

    // ********************************************************
    // registered outputs
    // ********************************************************
    // half-bridge gates drop on the edge the state moves, so no pulse leaks into
    // fault or lockout while the oscillator is being stopped
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            high_side_gate <= 1'b0;
        end else begin
            high_side_gate <= hi_on && nxt_state == state_ff;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bottom_switch_gate <= 1'b0;
        end else begin
            bottom_switch_gate <= lo_on && nxt_state == state_ff;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            boost_switch_gate <= 1'b0;
        end else begin
            boost_switch_gate <= boost_on_ff && osc_en;
        end
    end

    // timing nodes stay grounded whenever the oscillator is stopped
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            preheat_timer_node_discharge <= 1'b1;
        end else begin
            preheat_timer_node_discharge <= !osc_en;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            oscillator_timing_node_discharge <= 1'b1;
        end else begin
            oscillator_timing_node_discharge <= !osc_en;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            supply_discharge <= 1'b0;
        end else begin
            supply_discharge <= bus_latch_ff && !s_off_low;
        end
    end

    // state_out trails the state by one clock, like every output but the half-bridge gates, which drop on the edge the state moves
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_out <= BMFS_LOCKOUT;
        end else begin
            state_out <= state_ff;
        end
    end
endmodule

/* File: verification/bmfs_properties.sv */
// port checker for the ballast mode fault sequencer
`timescale 1ns/1ps
module bmfs_checker
    import bmfs_pkg::*;
#(
    parameter int FAULT_LIMIT = BMFS_FAULT_LIMIT
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic supply_off_low,
    input wire logic preheat_above_10v,
    input wire logic lamp_sense_above_3v,
    input wire logic lamp_sense_below_1v,
    input wire logic shutdown_above_5v2,
    input wire logic bus_sense_below_3v,
    input wire logic zero_current_seen,
    input wire logic high_side_gate,
    input wire logic bottom_switch_gate,
    input wire logic boost_switch_gate,
    input wire logic preheat_timer_node_discharge,
    input wire logic oscillator_timing_node_discharge,
    input wire logic supply_discharge,
    input bmfs_pkg::bmfs_state_e state_out
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic quiet;
    // the two recycle exits legally override run and fault
    assign quiet = !supply_off_low && !shutdown_above_5v2;

    chk_fault_gates_low: assert property (
        state_out == BMFS_FAULT && $past(state_out) == BMFS_FAULT
        |-> !high_side_gate && !bottom_switch_gate && !boost_switch_gate)
        else $error("gate active in fault");
    chk_fault_nodes_low: assert property (
        state_out == BMFS_FAULT && $past(state_out) == BMFS_FAULT
        |-> preheat_timer_node_discharge && oscillator_timing_node_discharge)
        else $error("timing node released in fault");
    chk_lockout_idle: assert property (
        state_out == BMFS_LOCKOUT && $past(state_out) == BMFS_LOCKOUT
        |-> !high_side_gate && !bottom_switch_gate
        && preheat_timer_node_discharge && oscillator_timing_node_discharge)
        else $error("lockout not idle");
    chk_gates_exclusive: assert property (
        !(high_side_gate && bottom_switch_gate))
        else $error("both half-bridge gates on");
    chk_dead_time: assert property (
        $fell(bottom_switch_gate) |-> !high_side_gate [*8])
        else $error("dead time too short");
    chk_warm_holds: assert property (
        (state_out == BMFS_WARM && !preheat_above_10v) [*4]
        |=> state_out != BMFS_STRIKE)
        else $error("strike without preheat level");
    chk_run_lamp_fault: assert property (
        state_out == BMFS_RUN && quiet && !bus_sense_below_3v
        && (lamp_sense_above_3v || lamp_sense_below_1v)
        |-> ##[1:5] state_out == BMFS_FAULT)
        else $error("lamp sense fault missed");
    chk_fault_latched: assert property (
        (state_out == BMFS_FAULT && quiet) [*4] |=> state_out == BMFS_FAULT)
        else $error("fault left without recycle");
    chk_boost_waits_zero: assert property (
        $fell(boost_switch_gate) ##1 (!zero_current_seen) [*8]
        |=> !boost_switch_gate)
        else $error("boost on before zero current");
    cover property (state_out == BMFS_RUN);
    cover property (state_out == BMFS_FAULT);
    cover property (supply_discharge);
endmodule

bind bmfs_top bmfs_checker #(.FAULT_LIMIT(FAULT_LIMIT)) u_chk (.*);

/* File: verification/bmfs_stage.sv */
// behavioural half-bridge output stage and boost converter
`timescale 1ns/1ps
module bmfs_stage (
    input wire logic clock,
    input wire logic high_side_gate,
    input wire logic bottom_switch_gate,
    input wire logic boost_switch_gate,
    input wire logic [1:0] oc_mode,
    output logic current_sense_over,
    output logic zero_current_seen
);
    // ****************************************
    // stage model
    // ****************************************
    logic [7:0] on_ff = 8'h00;
    logic [7:0] off_ff = 8'h00;
    logic hard_sw;
    // mode bit 1 puts the over-current on the wrong switch on purpose
    assign hard_sw = (oc_mode[0] && bottom_switch_gate)
        || (oc_mode[1] && high_side_gate);
    always @(negedge clock) begin
        on_ff <= hard_sw ? on_ff + 8'h01 : 8'h00;
        current_sense_over <= hard_sw && on_ff >= 8'h08 && on_ff < 8'h0C;
        // inductor takes a while to empty, so zero current lags the gate
        off_ff <= boost_switch_gate ? 8'h00 : off_ff + {7'h00, off_ff != 8'hFF};
        zero_current_seen <= !boost_switch_gate && off_ff > 8'h20;
    end
endmodule

/* File: verification/bmfs_top_tb_top.sv */
// self-checking bench for the ballast mode fault sequencer
`timescale 1ns/1ps
module bmfs_top_tb_top;
    import bmfs_pkg::*;
    logic clock;
    logic sys_rst = 1'h1, supply_on_ok = 1'h0, supply_off_low = 1'h0;
    logic preheat_above_10v = 1'h0, lamp_sense_above_3v = 1'h0;
    logic lamp_sense_below_1v = 1'h0, shutdown_above_5v2 = 1'h0;
    logic shutdown_below_5v0 = 1'h0, bus_sense_below_3v = 1'h0;
    logic spare_flag = 1'h0, loose = 1'h0, cs_q = 1'h0;
    logic [1:0] oc_mode = 2'h0;
    logic current_sense_over, zero_current_seen, high_side_gate;
    logic bottom_switch_gate, boost_switch_gate, supply_discharge;
    logic preheat_timer_node_discharge, oscillator_timing_node_discharge;
    bmfs_state_e state_out, seen = BMFS_LOCKOUT, q[$];
    int n_fail = 0, comparisons = 0, n_oc = 0;

    bmfs_top uut (.*);
    bmfs_stage u_stage (.*);

    // ****************************************
    // clock, tasks and state monitor
    // ****************************************
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(string what, logic [11:0] exp, logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic final_report();
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wait_q(int lim);
        for (int i = 0; i < lim && q.size() > 0; i++) @(negedge clock);
        if (q.size() > 0) check("pending", 12'h0, 12'(q.size()));
        q.delete();
    endtask

    task automatic lo_width(logic [11:0] exp);
        int n;
        for (n = 0; n < 900 && bottom_switch_gate; n++) @(negedge clock);
        for (n = 0; n < 900 && !bottom_switch_gate; n++) @(negedge clock);
        for (n = 0; n < 900 && bottom_switch_gate; n++) @(negedge clock);
        check("on_time", exp, 12'(n));
    endtask

    task automatic recycle();
        logic sup;
        sup = 1'($urandom);
        preheat_above_10v = 1'h0;
        supply_off_low = sup;
        supply_on_ok = !sup;
        shutdown_above_5v2 = !sup;
        shutdown_below_5v0 = sup;
        q.push_back(BMFS_LOCKOUT);
        wait_q(50);
        repeat ($urandom_range(20, 1)) @(negedge clock);
        {supply_off_low, supply_on_ok} = 2'h1;
        {shutdown_above_5v2, shutdown_below_5v0} = 2'h1;
        q.push_back(BMFS_WARM);
        wait_q(50);
    endtask

    task automatic go_run();
        preheat_above_10v = 1'h1;
        q.push_back(BMFS_STRIKE);
        q.push_back(BMFS_RUN);
        wait_q(2000);
    endtask

    always @(posedge clock) begin
        cs_q <= current_sense_over;
        if (current_sense_over && !cs_q)
            n_oc++;
        if (!sys_rst && !loose && state_out !== seen)
            check("state", q.size() > 0 ? 12'(q.pop_front()) : 12'hFFF,
                12'(state_out));
        seen <= state_out;
    end

    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        final_report();
    end

    initial begin
        void'($urandom(32'h739A));
        repeat (2) @(negedge clock);
        sys_rst = 1'h0;
        {supply_on_ok, shutdown_below_5v0} = 2'h3;
        q.push_back(BMFS_WARM);
        wait_q(50);
        for (int i = 0; i < 200 && !high_side_gate && !bottom_switch_gate; i++)
            @(negedge clock);
        check("first", 12'h1, 12'({high_side_gate, bottom_switch_gate}));
        lo_width(BMFS_WARM_HALF);
        oc_mode = 2'h2;
        repeat (3000) @(negedge clock);
        n_oc = 0;
        oc_mode = 2'h1;
        q.push_back(BMFS_FAULT);
        wait_q(9000);
        check("oc_events", 12'(BMFS_FAULT_LIMIT + 1), 12'(n_oc));
        oc_mode = 2'h0;
        recycle();
        oc_mode = 2'h1;
        repeat (1900) @(negedge clock);
        oc_mode = 2'h0;
        check("oc_cleared", 12'(BMFS_WARM), 12'(state_out));
        for (int c = 0; c < 3; c++) begin
            go_run();
            lo_width(BMFS_RUN_HALF);
            lamp_sense_above_3v = (c == 0);
            lamp_sense_below_1v = (c == 1);
            oc_mode = {1'h0, c == 2};
            q.push_back(BMFS_FAULT);
            wait_q(900);
            {lamp_sense_above_3v, lamp_sense_below_1v, oc_mode} = 4'h0;
            recycle();
        end
        go_run();
        loose = 1'h1;
        bus_sense_below_3v = 1'h1;
        repeat (10) @(negedge clock);
        check("bus_uv", 12'h8, 12'({supply_discharge, high_side_gate,
            bottom_switch_gate, boost_switch_gate}));
        {bus_sense_below_3v, preheat_above_10v} = 2'h0;
        {supply_off_low, supply_on_ok} = 2'h2;
        repeat (10) @(negedge clock);
        check("uv_exit", 12'h0, 12'({supply_discharge, state_out}));
        loose = 1'h0;
        {supply_off_low, supply_on_ok} = 2'h1;
        q.push_back(BMFS_WARM);
        wait_q(50);
        final_report();
    end
endmodule
